// file: rtl/ptr_link.sv
// Bit engine of the bus slave, clocked by the host's bus clock.
// Assumes frame_rst_in is held high while the bus is idle and briefly
// at every start, while the bus clock stands high.
`timescale 1ns/1ps
module ptr_link
  import ptr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic        scl_in,
  input  wire logic        rst_in,
  input  wire logic        frame_rst_in,
  input  wire logic        sda_in,
  input  wire logic        ack_tg_in,
  input  wire logic [15:0] hold_in,
  output logic             sda_oe_out,
  output logic [7:0]       cmd_out,
  output logic             req_tg_out,
  output logic             bad_tg_out
);

  typedef struct packed {
    ptr_link_e  st;
    logic [2:0] cnt;
    logic [7:0] sr;
    logic       rw;
    logic [7:0] tx;
    logic [1:0] idx;
  } ptr_frm_s;

  // Survives a repeated start so a read can follow the command byte
  typedef struct packed {
    logic [7:0] cmd;
    logic       req_tg;
    logic       bad_tg;
    logic [1:0] ack_sy;
  } ptr_lnk_s;

  ptr_frm_s frm_ff;
  ptr_frm_s nxt_frm;
  ptr_lnk_s lnk_ff;
  ptr_lnk_s nxt_lnk;
  logic     drive;
  logic     sda_oe_ff;
  logic     frame_clr;
  logic     hold_ok;

  function automatic logic [7:0] f_tx(input logic [7:0] c,
                                      input logic [1:0] i,
                                      input logic ok,
                                      input logic [15:0] w);
    if (c == CMD_REV) begin
      return (i == 2'h0) ? REV_BYTE : IDLE_BYTE; // see RQ16 see RQ17
    end
    if (ptr_is_word(c) && ok) begin
      if (i == 2'h0) begin
        return w[7:0];
      end
      if (i == 2'h1) begin
        return w[15:8];
      end
    end
    return IDLE_BYTE;
  endfunction : f_tx

  assign frame_clr = rst_in | frame_rst_in;
  assign hold_ok   = (lnk_ff.ack_sy[1] == lnk_ff.req_tg); // see RQ18

  always_comb begin
    nxt_frm = frm_ff;
    nxt_lnk = lnk_ff;
    nxt_lnk.ack_sy = {lnk_ff.ack_sy[0], ack_tg_in};
    case (frm_ff.st)
      LK_ADDR, LK_CMD, LK_WDATA: begin
        nxt_frm.sr  = {frm_ff.sr[6:0], sda_in};
        nxt_frm.cnt = frm_ff.cnt + 3'h1;
        if (frm_ff.cnt == BIT_LAST) begin
          if (frm_ff.st == LK_ADDR) begin
            nxt_frm.rw = sda_in;
            nxt_frm.st = (frm_ff.sr[6:0] == DEV_ADDR) ? LK_AACK : LK_IGNORE;
          end else if (frm_ff.st == LK_CMD) begin
            nxt_lnk.cmd    = nxt_frm.sr;
            nxt_lnk.req_tg = ~lnk_ff.req_tg; // see RQ18
            nxt_frm.st     = LK_CACK;
          end else begin
            if (ptr_is_ro(lnk_ff.cmd)) begin
              nxt_lnk.bad_tg = ~lnk_ff.bad_tg; // see RQ15
            end
            nxt_frm.st = LK_WACK;
          end
        end
      end
      LK_AACK: begin
        nxt_frm.idx = 2'h0;
        if (frm_ff.rw) begin
          nxt_frm.st = LK_RDATA;
          nxt_frm.tx = f_tx(lnk_ff.cmd, 2'h0, hold_ok, hold_in); // see RQ1
        end else begin
          nxt_frm.st = LK_CMD;
        end
      end
      LK_CACK, LK_WACK: nxt_frm.st = LK_WDATA;
      LK_RDATA: begin
        nxt_frm.tx  = {frm_ff.tx[6:0], 1'b1};
        nxt_frm.cnt = frm_ff.cnt + 3'h1;
        if (frm_ff.cnt == BIT_LAST) begin
          nxt_frm.st  = LK_RACK;
          nxt_frm.idx = frm_ff.idx + 2'h1;
        end
      end
      LK_RACK: begin
        if (!sda_in) begin
          nxt_frm.st = LK_RDATA;
          nxt_frm.tx = f_tx(lnk_ff.cmd, frm_ff.idx, hold_ok, hold_in);
        end else begin
          nxt_frm.st = LK_IGNORE;
        end
      end
      default: nxt_frm.st = LK_IGNORE;
    endcase
  end

  // Data bytes of a read-only command are refused with a NACK
  always_comb begin
    drive = (frm_ff.st == LK_AACK) || (frm_ff.st == LK_CACK) ||
            ((frm_ff.st == LK_WACK) && !ptr_is_ro(lnk_ff.cmd)) ||
            ((frm_ff.st == LK_RDATA) && !frm_ff.tx[7]);
  end

  always_ff @(posedge scl_in or posedge frame_clr) begin
    if (frame_clr) begin
      frm_ff <= '{st: LK_ADDR, default: '0};
    end else begin
      frm_ff <= nxt_frm;
    end
  end

  always_ff @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      lnk_ff <= '0;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // Data changes only while the bus clock is low
  always_ff @(negedge scl_in or posedge frame_clr) begin
    if (frame_clr) begin
      sda_oe_ff <= 1'b0;
    end else begin
      sda_oe_ff <= drive;
    end
  end

  assign sda_oe_out = sda_oe_ff;
  assign cmd_out    = lnk_ff.cmd;
  assign req_tg_out = lnk_ff.req_tg;
  assign bad_tg_out = lnk_ff.bad_tg;

  a_rev_byte_value: assert property ( // see RQ17
    @(posedge scl_in) disable iff (frame_clr)
    (frm_ff.st == LK_AACK && frm_ff.rw && lnk_ff.cmd == CMD_REV)
    |=> frm_ff.tx == REV_BYTE && frm_ff.st == LK_RDATA)
    else $error("revision byte not loaded");

  a_word_low_first: assert property ( // see RQ1
    @(posedge scl_in) disable iff (frame_clr)
    (frm_ff.st == LK_AACK && frm_ff.rw && hold_ok &&
     ptr_is_word(lnk_ff.cmd))
    |=> frm_ff.tx == $past(hold_in[7:0]))
    else $error("read word did not start with low byte");

  a_ro_write_nack: assert property ( // see RQ15
    @(posedge scl_in) disable iff (frame_clr)
    (frm_ff.st == LK_WDATA && frm_ff.cnt == BIT_LAST &&
     ptr_is_ro(lnk_ff.cmd))
    |=> frm_ff.st == LK_WACK && !drive && $changed(lnk_ff.bad_tg))
    else $error("write to read-only command not flagged");

endmodule : ptr_link

// file: rtl/ptr_pkg.sv
// Constants, command codes and state types for the telemetry readback.
// Assumes a 100 MHz system clock; the link runs on the host's bus clock.
package ptr_pkg;

  localparam int CLK_PERIOD_NS       = 10;
  localparam int REFRESH_MS          = 1;
  localparam int REFRESH_CYCLES      = REFRESH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TEMP_REFRESH_US     = 300;
  localparam int TEMP_REFRESH_CYCLES = TEMP_REFRESH_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W               = 20;

  localparam logic [7:0] CMD_VIN   = 8'h88;
  localparam logic [7:0] CMD_VOUT  = 8'h8B;
  localparam logic [7:0] CMD_IOUT  = 8'h8C;
  localparam logic [7:0] CMD_TEMP  = 8'h8D;
  localparam logic [7:0] CMD_REV   = 8'h98;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] REV_PART1 = 4'h3;
  localparam logic [3:0] REV_PART2 = 4'h3;
  localparam logic [7:0] REV_BYTE  = {REV_PART1, REV_PART2};

  // Linear word layout: exponent 15:11, mantissa 10:0
  localparam int EXP_MSB   = 15;
  localparam int EXP_LSB   = 11;
  localparam int MANT_MSB  = 10;
  localparam int MANT_MAX  = 1023;
  localparam int MANT_MIN  = -1024;
  localparam int BAD_CMD_BIT = 7;

  localparam int VIN_EXP     = -5;
  localparam int IOUT_EXP    = -2;
  localparam int TEMP_EXP    = 0;
  localparam int VOUT_EXP    = -9;
  localparam int VIN_MAX_V   = 24;
  localparam int IOUT_MIN_A  = -15;
  localparam int IOUT_MAX_A  = 90;
  localparam int TEMP_MIN_C  = -40;
  localparam int TEMP_MAX_C  = 175;
  localparam int VOUT_MAX_MV = 6000;
  localparam int VIN_MAX_M   = VIN_MAX_V * (2 ** (-VIN_EXP));
  localparam int IOUT_LO_M   = IOUT_MIN_A * (2 ** (-IOUT_EXP));
  localparam int IOUT_HI_M   = IOUT_MAX_A * (2 ** (-IOUT_EXP));
  localparam logic [15:0] VOUT_MAX_W =
    16'(VOUT_MAX_MV * (2 ** (-VOUT_EXP)) / 1000);

  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h24;
  localparam logic [2:0] BIT_LAST         = 3'h7;
  localparam logic [1:0] RESTART_HOLD     = 2'h2;

  typedef enum logic [3:0] {
    LK_ADDR, LK_AACK, LK_CMD, LK_CACK, LK_WDATA,
    LK_WACK, LK_RDATA, LK_RACK, LK_IGNORE
  } ptr_link_e;

  function automatic logic ptr_is_word(input logic [7:0] c);
    return (c == CMD_VIN) || (c == CMD_VOUT) || (c == CMD_IOUT) ||
           (c == CMD_TEMP);
  endfunction : ptr_is_word

  function automatic logic ptr_is_ro(input logic [7:0] c);
    return ptr_is_word(c) || (c == CMD_REV);
  endfunction : ptr_is_ro

endpackage : ptr_pkg

// file: rtl/ptr_readback.sv
// Telemetry readback for a stacked power stage: samples per-device
// readings, publishes linear words, answers the host over the bus.
// Assumes readings arrive on CLOCK_IN and the host drives the bus clock.
`timescale 1ns/1ps
// Summary of operation
// RQ1: Command 88h returns a two-byte input voltage word, refreshed each 1 ms.
// RQ2: Signed linear words hold exponent in bits 15:11, mantissa 10:0.
// RQ3: Input voltage reading is held within zero to 24 V.
// RQ4: Phase FFh: input voltage comes from the loop controller device.
// RQ5: Other phase: input voltage comes from the selected phase's device.
// RQ6: Command 8Bh returns unsigned output voltage, 1 ms refresh, 0 to 6.0 V.
// RQ7: Loop follower reports raw sense pin voltage, divider ignored.
// RQ8: Command 8Ch returns signed current, 1 ms refresh, -15 to 90 A.
// RQ9: Phase FFh: current is the sum over all stacked devices.
// RQ10: Other phase: current of the selected phase's device only.
// RQ11: Command 8Dh returns hottest stage temperature, -40 to 175 C.
// RQ12: Phase FFh: temperature of the hottest device in the stack.
// RQ13: Other phase: temperature of the selected phase's device.
// RQ14: Temperature word steps one degree Celsius per count.
// RQ15: Writes to these commands set comm fault, status bit 7, alert.
// RQ16: Command 98h returns one byte, within 0.25 ms.
// RQ17: Revision byte reads 0011b in both nibbles.
// RQ18: Every word read comes from one coherent sample.
module ptr_readback
  import ptr_pkg::*;
#(
  parameter int         NUM_DEV     = 2,
  parameter int         REFRESH_CNT = REFRESH_CYCLES,
  parameter int         TEMP_CNT    = TEMP_REFRESH_CYCLES,
  parameter logic [6:0] DEV_ADDR    = DEV_ADDR_DEFAULT
) (
  input  wire logic                      CLOCK_IN,
  input  wire logic                      RST_IN,
  input  wire logic                      PM_SCL_IN,
  input  wire logic                      PM_SDA_IN,
  output logic                           PM_SDA_OUT,
  output logic                           PM_SDA_OE_OUT,
  output logic                           ALERT_OUT,
  output logic                           ALERT_OE_OUT,
  input  wire logic [7:0]                PHASE_IN,
  input  wire logic                      LOOP_FOLLOWER_IN,
  input  wire logic [NUM_DEV-1:0][10:0]  VIN_MANT_IN,
  input  wire logic [NUM_DEV-1:0][10:0]  IOUT_MANT_IN,
  input  wire logic [NUM_DEV-1:0][10:0]  TEMP_MANT_IN,
  input  wire logic [15:0]               VOUT_IN,
  input  wire logic [15:0]               SENSE_RAW_IN,
  input  wire logic                      CLEAR_FAULTS_IN,
  output logic [7:0]                     COMM_STATUS_OUT,
  output logic                           SUMMARY_FAULT_OUT
);

  typedef struct packed {
    logic [2:0]       scl_sy;
    logic [2:0]       sda_sy;
    logic             idle;
    logic [1:0]       hold_cnt;
    logic             frame_rst;
    logic [CNT_W-1:0] ref_cnt;
    logic [CNT_W-1:0] tmp_cnt;
    logic [15:0]      vin;
    logic [15:0]      vout;
    logic [15:0]      iout;
    logic [15:0]      temp;
    logic [2:0]       req_sy;
    logic [2:0]       bad_sy;
    logic             ack_tg;
    logic [15:0]      hold;
    logic [7:0]       comm_status;
    logic             comm_fault;
  } ptr_sys_s;

  // Pins idle high, so the samplers start high and see no false edge
  localparam ptr_sys_s SYS_RST = '{scl_sy: '1, sda_sy: '1, idle: 1'b1,
                                   frame_rst: 1'b1, default: '0};
  localparam logic [CNT_W-1:0] REF_LAST = CNT_W'(REFRESH_CNT - 1);
  localparam logic [CNT_W-1:0] TMP_LAST = CNT_W'(TEMP_CNT - 1);

  ptr_sys_s    cur_ff;
  ptr_sys_s    nxt_cur;
  logic [7:0]  link_cmd;
  logic        link_req_tg;
  logic        link_bad_tg;
  logic        link_sda_oe;
  logic        link_rst;
  logic        start_seen;
  logic        stop_seen;
  logic        ref_tick;
  logic        tmp_tick;
  logic        req_edge;
  logic        bad_edge;
  logic        all_phases;
  logic [10:0] vin_m;
  logic [10:0] iout_m;
  logic [10:0] temp_m;
  logic [15:0] vout_w;

  // Phases with no device behind them fall back to the controller
  function automatic logic [10:0] f_pick(
      input logic [NUM_DEV-1:0][10:0] v, input logic [7:0] ph);
    logic [10:0] r;
    r = v[0];
    for (int i = 1; i < NUM_DEV; i++) begin
      if (ph == 8'(i)) begin
        r = v[i];
      end
    end
    return r;
  endfunction : f_pick

  function automatic logic [10:0] f_clamp(input logic [10:0] m,
                                          input int lo, input int hi);
    if (int'($signed(m)) < lo) begin
      return 11'(lo);
    end
    if (int'($signed(m)) > hi) begin
      return 11'(hi);
    end
    return m;
  endfunction : f_clamp

  // Each phase is limited first so one bad sensor cannot swamp the total
  function automatic logic [10:0] f_sum(
      input logic [NUM_DEV-1:0][10:0] v);
    int s;
    s = 0;
    for (int i = 0; i < NUM_DEV; i++) begin
      s = s + int'($signed(f_clamp(v[i], IOUT_LO_M, IOUT_HI_M)));
    end
    if (s > MANT_MAX) begin
      s = MANT_MAX;
    end
    if (s < MANT_MIN) begin
      s = MANT_MIN;
    end
    return 11'(s);
  endfunction : f_sum

  function automatic logic [10:0] f_max(
      input logic [NUM_DEV-1:0][10:0] v);
    logic [10:0] r;
    r = v[0];
    for (int i = 1; i < NUM_DEV; i++) begin
      if ($signed(v[i]) > $signed(r)) begin
        r = v[i];
      end
    end
    return r;
  endfunction : f_max

  function automatic logic [15:0] f_word(input ptr_sys_s s,
                                         input logic [7:0] c);
    case (c)
      CMD_VIN:  return s.vin;
      CMD_VOUT: return s.vout;
      CMD_IOUT: return s.iout;
      CMD_TEMP: return s.temp;
      default:  return {IDLE_BYTE, IDLE_BYTE};
    endcase
  endfunction : f_word

  assign all_phases = (PHASE_IN == PHASE_ALL);

  always_comb begin
    if (all_phases) begin
      vin_m  = f_clamp(VIN_MANT_IN[0], 0, VIN_MAX_M); // see RQ3 see RQ4
      iout_m = f_sum(IOUT_MANT_IN); // see RQ9
      temp_m = f_clamp(f_max(TEMP_MANT_IN), TEMP_MIN_C,
                       TEMP_MAX_C); // see RQ12
    end else begin
      vin_m  = f_clamp(f_pick(VIN_MANT_IN, PHASE_IN), 0,
                       VIN_MAX_M); // see RQ5
      iout_m = f_clamp(f_pick(IOUT_MANT_IN, PHASE_IN), IOUT_LO_M,
                       IOUT_HI_M); // see RQ8 see RQ10
      temp_m = f_clamp(f_pick(TEMP_MANT_IN, PHASE_IN), TEMP_MIN_C,
                       TEMP_MAX_C); // see RQ11 see RQ13
    end
    // Keeping the sense range within 0.75 V is up to the board
    if (LOOP_FOLLOWER_IN) begin
      vout_w = SENSE_RAW_IN; // see RQ7
    end else if (VOUT_IN > VOUT_MAX_W) begin
      vout_w = VOUT_MAX_W; // see RQ6
    end else begin
      vout_w = VOUT_IN;
    end
  end

  // Only the second and third synchroniser stages are looked at
  assign start_seen = cur_ff.scl_sy[2] & cur_ff.scl_sy[1] &
                      cur_ff.sda_sy[2] & ~cur_ff.sda_sy[1];
  assign stop_seen  = cur_ff.scl_sy[2] & cur_ff.scl_sy[1] &
                      ~cur_ff.sda_sy[2] & cur_ff.sda_sy[1];
  assign ref_tick   = (cur_ff.ref_cnt == REF_LAST);
  assign tmp_tick   = (cur_ff.tmp_cnt == TMP_LAST);
  assign req_edge   = cur_ff.req_sy[2] ^ cur_ff.req_sy[1];
  assign bad_edge   = cur_ff.bad_sy[2] ^ cur_ff.bad_sy[1];

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.scl_sy = {cur_ff.scl_sy[1:0], PM_SCL_IN};
    nxt_cur.sda_sy = {cur_ff.sda_sy[1:0], PM_SDA_IN};
    nxt_cur.req_sy = {cur_ff.req_sy[1:0], link_req_tg};
    nxt_cur.bad_sy = {cur_ff.bad_sy[1:0], link_bad_tg};
    // A start also re-arms the bit engine on a repeated start
    if (start_seen) begin
      nxt_cur.idle     = 1'b0;
      nxt_cur.hold_cnt = RESTART_HOLD;
    end else if (cur_ff.hold_cnt != 2'h0) begin
      nxt_cur.hold_cnt = cur_ff.hold_cnt - 2'h1;
    end
    if (stop_seen) begin
      nxt_cur.idle = 1'b1;
    end
    nxt_cur.frame_rst = nxt_cur.idle | (nxt_cur.hold_cnt != 2'h0);
    nxt_cur.ref_cnt = ref_tick ? '0 : cur_ff.ref_cnt + CNT_W'(1);
    nxt_cur.tmp_cnt = tmp_tick ? '0 : cur_ff.tmp_cnt + CNT_W'(1);
    if (ref_tick) begin
      nxt_cur.vin  = {5'(VIN_EXP), vin_m}; // see RQ1 see RQ2
      nxt_cur.vout = vout_w; // see RQ6
      nxt_cur.iout = {5'(IOUT_EXP), iout_m}; // see RQ2 see RQ8
    end
    if (tmp_tick) begin
      nxt_cur.temp = {5'(TEMP_EXP), temp_m}; // see RQ14
    end
    // Word frozen at the command byte; later refreshes leave it alone
    if (req_edge) begin
      nxt_cur.hold   = f_word(cur_ff, link_cmd); // see RQ18
      nxt_cur.ack_tg = ~cur_ff.ack_tg;
    end
    if (CLEAR_FAULTS_IN) begin
      nxt_cur.comm_status = 8'h00;
      nxt_cur.comm_fault  = 1'b0;
    end
    // A fault in the clearing cycle still lands
    if (bad_edge) begin
      nxt_cur.comm_status[BAD_CMD_BIT] = 1'b1; // see RQ15
      nxt_cur.comm_fault               = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cur_ff <= SYS_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link_rst = cur_ff.frame_rst;

  ptr_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .scl_in       (PM_SCL_IN),
    .rst_in       (RST_IN),
    .frame_rst_in (link_rst),
    .sda_in       (PM_SDA_IN),
    .ack_tg_in    (cur_ff.ack_tg),
    .hold_in      (cur_ff.hold),
    .sda_oe_out   (link_sda_oe),
    .cmd_out      (link_cmd),
    .req_tg_out   (link_req_tg),
    .bad_tg_out   (link_bad_tg)
  );

  assign PM_SDA_OUT      = 1'b0;
  assign PM_SDA_OE_OUT   = link_sda_oe;
  assign ALERT_OUT       = 1'b0;
  assign ALERT_OE_OUT      = cur_ff.comm_fault; // see RQ15
  assign COMM_STATUS_OUT   = cur_ff.comm_status;
  assign SUMMARY_FAULT_OUT = cur_ff.comm_fault;

  sequence s_ref_tick;
    ref_tick;
  endsequence

  sequence s_fault_in;
    bad_edge;
  endsequence

  sequence s_flags_up;
    COMM_STATUS_OUT[BAD_CMD_BIT] && SUMMARY_FAULT_OUT && ALERT_OE_OUT;
  endsequence

  a_bad_cmd_flags: assert property ( // see RQ15
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_fault_in |=> s_flags_up)
    else $error("invalid command fault not raised");

  a_fault_flag_sticky: assert property ( // see RQ15
    @(posedge CLOCK_IN) disable iff (RST_IN)
    SUMMARY_FAULT_OUT && !CLEAR_FAULTS_IN |=> SUMMARY_FAULT_OUT)
    else $error("fault flag dropped without a clear");

  a_refresh_period: assert property ( // see RQ1
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick |=> cur_ff.ref_cnt == '0 ##1 !ref_tick [*8])
    else $error("refresh tick period wrong");

  a_lin_exponents: assert property ( // see RQ2
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick |=> cur_ff.vin[EXP_MSB:EXP_LSB] == 5'(VIN_EXP) &&
                   cur_ff.iout[EXP_MSB:EXP_LSB] == 5'(IOUT_EXP))
    else $error("linear exponent field wrong");

  a_vin_range: assert property ( // see RQ3
    @(posedge CLOCK_IN) disable iff (RST_IN)
    !cur_ff.vin[MANT_MSB] &&
    int'(cur_ff.vin[MANT_MSB:0]) <= VIN_MAX_M)
    else $error("input voltage outside span");

  a_vin_controller: assert property ( // see RQ4
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick ##0 (all_phases && !VIN_MANT_IN[0][MANT_MSB] &&
                    int'(VIN_MANT_IN[0]) <= VIN_MAX_M)
    |=> cur_ff.vin[MANT_MSB:0] == $past(VIN_MANT_IN[0]))
    else $error("input voltage not from controller");

  a_iout_one_phase: assert property ( // see RQ10
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick ##0 (NUM_DEV > 1 && PHASE_IN == 8'h01)
    |=> cur_ff.iout[MANT_MSB:0] ==
        f_clamp($past(IOUT_MANT_IN[NUM_DEV > 1 ? 1 : 0]),
                IOUT_LO_M, IOUT_HI_M))
    else $error("phase current not from selected device");

  a_iout_total: assert property ( // see RQ9
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick ##0 all_phases
    |=> cur_ff.iout[MANT_MSB:0] == f_sum($past(IOUT_MANT_IN)))
    else $error("stack current is not the sum");

  a_temp_hottest: assert property ( // see RQ12
    @(posedge CLOCK_IN) disable iff (RST_IN)
    tmp_tick && all_phases
    |=> $signed(cur_ff.temp[MANT_MSB:0]) >=
        $signed(f_clamp($past(TEMP_MANT_IN[0]), TEMP_MIN_C,
                        TEMP_MAX_C)))
    else $error("stack temperature below a device");

  a_temp_span: assert property ( // see RQ11
    @(posedge CLOCK_IN) disable iff (RST_IN)
    $rose(tmp_tick) |=> int'($signed(cur_ff.temp[MANT_MSB:0])) >= TEMP_MIN_C
      && int'($signed(cur_ff.temp[MANT_MSB:0])) <= TEMP_MAX_C
      && cur_ff.temp[EXP_MSB:EXP_LSB] == 5'(TEMP_EXP))
    else $error("temperature word out of span");

  a_follower_raw: assert property ( // see RQ7
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick ##0 LOOP_FOLLOWER_IN |=> cur_ff.vout == $past(SENSE_RAW_IN))
    else $error("follower did not report raw sense");

  a_vout_span: assert property ( // see RQ6
    @(posedge CLOCK_IN) disable iff (RST_IN)
    s_ref_tick ##0 !LOOP_FOLLOWER_IN |=> cur_ff.vout <= VOUT_MAX_W)
    else $error("output voltage above span");

  a_hold_coherent: assert property ( // see RQ18
    @(posedge CLOCK_IN) disable iff (RST_IN)
    !req_edge |=> $stable(cur_ff.hold) && $stable(cur_ff.ack_tg))
    else $error("held word changed without a request");

endmodule : ptr_readback

// file: testbench/ptr_host_model.sv
// Behavioural bus host: start, restart, stop and byte transfers.
// Assumes a pull-up on the data wire; bus clock stands high when idle.
`timescale 1ns/1ps
module ptr_host_model (
  output logic      scl_out,
  output logic      sda_oe_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Data set while the clock is low, sampled at the rising edge
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out = ~b;
    #16 scl_out = 1'b1;
    r = sda_in;
    #16 scl_out = 1'b0;
  endtask : bit_io

  // Serves as restart too: releases data before raising the clock
  task automatic start();
    sda_oe_out = 1'b0;
    #16 scl_out = 1'b1;
    #100 sda_oe_out = 1'b1;
    #100 scl_out = 1'b0;
  endtask : start

  task automatic stop();
    sda_oe_out = 1'b1;
    #16 scl_out = 1'b1;
    #100 sda_oe_out = 1'b0;
    #100;
  endtask : stop

  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack);
  endtask : byte_io
endmodule : ptr_host_model

// file: testbench/ptr_readback_tb_top.sv
// Self-checking bench for the telemetry readback with a two-device stack.
// Assumes the host model above; refresh counts shortened for run time.
`timescale 1ns/1ps
module ptr_readback_tb_top;
  import ptr_pkg::*;
  logic             clk = 1'b0;
  logic             rst;
  logic             scl, hoe, sda_oe, alert_oe, flt, fol, clr, sdo, alo;
  logic [7:0]       phase, status;
  logic [1:0][10:0] vin, iout, temp;
  logic [15:0]      vout, sraw;
  int               err_count = 0;
  int               compares = 0;
  wire              sda = ~(hoe | sda_oe);

  always #5 clk = ~clk;

  ptr_host_model host (.scl_out(scl), .sda_oe_out(hoe), .sda_in(sda));
  ptr_readback #(.NUM_DEV(2), .REFRESH_CNT(50), .TEMP_CNT(40)) uut (
    .CLOCK_IN(clk), .RST_IN(rst), .PM_SCL_IN(scl), .PM_SDA_IN(sda),
    .PM_SDA_OUT(sdo), .PM_SDA_OE_OUT(sda_oe), .ALERT_OUT(alo),
    .ALERT_OE_OUT(alert_oe), .PHASE_IN(phase), .LOOP_FOLLOWER_IN(fol),
    .VIN_MANT_IN(vin), .IOUT_MANT_IN(iout), .TEMP_MANT_IN(temp),
    .VOUT_IN(vout), .SENSE_RAW_IN(sraw), .CLEAR_FAULTS_IN(clr),
    .COMM_STATUS_OUT(status), .SUMMARY_FAULT_OUT(flt));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] c, input logic wd,
                    output logic [15:0] w);
    logic [7:0] q;
    logic       a;
    host.start();
    host.byte_io({7'h24, 1'b0}, 1'b1, q, a);
    host.byte_io(c, 1'b1, q, a);
    host.start();
    host.byte_io({7'h24, 1'b1}, 1'b1, q, a);
    host.byte_io(8'hFF, ~wd, w[7:0], a);
    w[15:8] = 8'h00;
    if (wd) host.byte_io(8'hFF, 1'b1, w[15:8], a);
    host.stop();
  endtask : rd

  task automatic t_rev();
    logic [15:0] w;
    rd(8'h98, 1'b0, w);
    chk(w, 16'h0033);
  endtask : t_rev

  // Phase change needs a refresh before the new selection shows
  task automatic t_phase(input logic [7:0] p, input logic [15:0] ev,
                         input logic [15:0] ei, input logic [15:0] et);
    logic [15:0] w;
    @(posedge clk);
    phase <= p;
    repeat (120) @(posedge clk);
    rd(8'h88, 1'b1, w);
    chk(w, ev);
    rd(8'h8C, 1'b1, w);
    chk(w, ei);
    rd(8'h8D, 1'b1, w);
    chk(w, et);
  endtask : t_phase

  task automatic t_vout();
    logic [15:0] w;
    rd(8'h8B, 1'b1, w);
    chk(w, 16'h0600);
    @(posedge clk);
    vout <= 16'hD000;
    repeat (120) @(posedge clk);
    rd(8'h8B, 1'b1, w);
    chk(w, VOUT_MAX_W);
    @(posedge clk);
    fol <= 1'b1;
    repeat (120) @(posedge clk);
    rd(8'h8B, 1'b1, w);
    chk(w, 16'h0100);
  endtask : t_vout

  // Every read-only code must refuse a data byte and raise the fault
  task automatic t_wrro();
    logic [7:0] cl[5] = '{8'h88, 8'h8B, 8'h8C, 8'h8D, 8'h98};
    logic [7:0] q;
    logic       a;
    foreach (cl[i]) begin
      chk(status, 16'h0000);
      host.start();
      host.byte_io({7'h24, 1'b0}, 1'b1, q, a);
      host.byte_io(cl[i], 1'b1, q, a);
      host.byte_io(8'h5A, 1'b1, q, a);
      chk(a, 1'b1);
      host.stop();
      repeat (10) @(posedge clk);
      chk({status[7], flt, alert_oe}, 16'h0007);
      chk({sdo, alo}, 16'h0000);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : t_wrro

  task automatic wrap_up();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    #300000;
    err_count++;
    wrap_up();
  end

  initial begin
    // Raised after all processes wait, so the bus-side resets see an edge
    rst <= 1'b1;
    phase <= 8'hFF;
    fol <= 1'b0;
    clr <= 1'b0;
    vin <= {11'h180, 11'h190};
    iout <= {11'h030, 11'h028};
    temp <= {11'h7EC, 11'h032};
    vout <= 16'h0600;
    sraw <= 16'h0100;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (120) @(posedge clk);
    t_rev();
    t_phase(8'hFF, 16'hD990, 16'hF058, 16'h0032);
    t_phase(8'h01, 16'hD980, 16'hF030, 16'h07EC);
    t_vout();
    t_wrro();
    wrap_up();
  end
endmodule : ptr_readback_tb_top
